// file: hdl/mrf_ctrl.sv
`timescale 1ns/1ps
`include "mrf_map.svh"
`default_nettype none

module mrf_ctrl (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_sof,
    input wire logic rx_eof,
    input wire logic [5:0] rx_hash_idx,
    input wire logic rx_wake_match,
    output logic rx_out_valid,
    output logic [7:0] rx_out_data,
    output logic rx_out_end,
    output logic rx_out_accept,
    output logic wake_event,
    input wire logic tx_frame_start,
    input wire logic tx_collision,
    input wire logic tx_late_collision,
    input wire logic tx_done,
    output logic tx_retry,
    output logic tx_abandon,
    output logic tx_status_valid,
    output logic [31:0] tx_status
);

    logic rst_meta_q;
    logic rst_n_q;
    mrf_pkg::mrf_state_t s_q;
    mrf_pkg::mrf_state_t s_d;

    // release reset only on a clock edge so the state never sees a runt release
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    logic hash_sel;
    logic hash_only;
    logic late_retry;
    logic broadcast_block_block;
    logic single_tx;
    logic pad_strip;
    logic [63:0] hash_tbl;
    logic [7:0] da_expect;
    logic byte_match;
    logic match_now;
    logic broadcast_block_now;
    logic mcast_now;
    logic hash_hit;
    logic accept_now;
    logic [15:0] len_now;
    logic [15:0] keep_limit;
    logic strip_now;
    logic drop_byte;
    logic [10:0] cnt_now;
    logic col_now;
    logic [4:0] att_next;
    logic apb_access;
    logic [5:0] reg_idx;

    assign hash_sel = s_q.mac_control[`MRF_BIT_HASH_SEL];
    assign hash_only = s_q.mac_control[`MRF_BIT_HASH_ONLY];
    assign late_retry = s_q.mac_control[`MRF_BIT_LATE_RETRY];
    assign broadcast_block_block = s_q.mac_control[`MRF_BIT_BROADCAST_BLOCK_BLOCK];
    assign single_tx = s_q.mac_control[`MRF_BIT_SINGLE_TX];
    assign pad_strip = s_q.mac_control[`MRF_BIT_PAD_STRIP];
    assign hash_tbl = {s_q.hash_high, s_q.hash_low};
    assign apb_access = psel && penable;
    assign reg_idx = paddr[7:2];
    assign cnt_now = rx_sof ? 11'h000 : s_q.rx_cnt;
    assign col_now = tx_collision || tx_late_collision;
    assign att_next = s_q.tx_attempts + 5'd1;

    // station address goes out first byte first: low word, then high half
    always_comb
    begin
        unique case (cnt_now[2:0])
            3'd0: da_expect = s_q.addr_low[7:0];
            3'd1: da_expect = s_q.addr_low[15:8];
            3'd2: da_expect = s_q.addr_low[23:16];
            3'd3: da_expect = s_q.addr_low[31:24];
            3'd4: da_expect = s_q.addr_high[7:0];
            default: da_expect = s_q.addr_high[15:8];
        endcase
    end

    assign byte_match = (rx_data == da_expect);
    assign hash_hit = hash_tbl[rx_hash_idx];
    assign match_now = s_q.da_match;
    assign broadcast_block_now = s_q.da_broadcast_block;
    assign mcast_now = s_q.da_mcast;
    assign len_now = s_q.len_field;
    assign keep_limit = len_now + `MRF_HDR_BYTES;
    // length only known after byte 13, so the header always passes
    assign strip_now = pad_strip && (s_q.rx_cnt > `MRF_LEN_LO_POS)
        && (len_now < `MRF_MIN_PAYLOAD);
    assign drop_byte = strip_now && ({5'h00, cnt_now} >= keep_limit);

    always_comb
    begin
        if (broadcast_block_now)
        begin
            accept_now = !broadcast_block_block;
        end
        else if (!hash_sel)
        begin
            accept_now = match_now;
        end
        else if (mcast_now)
        begin
            accept_now = hash_hit;
        end
        else
        begin
            accept_now = hash_only ? hash_hit : match_now;
        end
    end

    always_comb
    begin
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.rx_out_valid = 1'b0;
        s_d.rx_out_end = 1'b0;
        s_d.wake_event = 1'b0;
        s_d.tx_retry = 1'b0;
        s_d.tx_abandon = 1'b0;
        s_d.tx_status_valid = 1'b0;

        // one wait state: answer in the second access cycle, write lands with pready
        if (apb_access && !s_q.pready)
        begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0000_0000;
            unique case (reg_idx)
                `MRF_IDX_MAC_CONTROL: s_d.prdata = s_q.mac_control;
                `MRF_IDX_ADDR_HIGH: s_d.prdata = {16'h0000, s_q.addr_high};
                `MRF_IDX_ADDR_LOW: s_d.prdata = s_q.addr_low;
                `MRF_IDX_HASH_HIGH: s_d.prdata = s_q.hash_high;
                `MRF_IDX_HASH_LOW: s_d.prdata = s_q.hash_low;
                `MRF_IDX_WAKE_CTRL: s_d.prdata[`MRF_BIT_WAKE_EN] = s_q.wake_en;
                `MRF_IDX_TX_STATUS: s_d.prdata = s_q.tx_status;
                default: s_d.pslverr = 1'b1;
            endcase
            if (pwrite)
            begin
                s_d.prdata = 32'h0000_0000;
            end
        end
        else if (apb_access && s_q.pready && pwrite)
        begin
            unique case (reg_idx)
                `MRF_IDX_MAC_CONTROL: s_d.mac_control = pwdata;
                `MRF_IDX_ADDR_HIGH: s_d.addr_high = pwdata[15:0];
                `MRF_IDX_ADDR_LOW: s_d.addr_low = pwdata;
                `MRF_IDX_HASH_HIGH: s_d.hash_high = pwdata;
                `MRF_IDX_HASH_LOW: s_d.hash_low = pwdata;
                `MRF_IDX_WAKE_CTRL: s_d.wake_en = pwdata[`MRF_BIT_WAKE_EN];
                default: s_d.wake_en = s_q.wake_en;
            endcase
        end

        // receive: destination check and length capture run on the fly
        if (rx_valid)
        begin
            if (cnt_now != `MRF_CNT_MAX)
            begin
                s_d.rx_cnt = cnt_now + 11'd1;
            end
            if (cnt_now == 11'h000)
            begin
                s_d.da_match = byte_match;
                s_d.da_broadcast_block = (rx_data == 8'hff);
                s_d.da_mcast = rx_data[0];
            end
            else if (cnt_now <= `MRF_DA_LAST)
            begin
                s_d.da_match = s_q.da_match && byte_match;
                s_d.da_broadcast_block = s_q.da_broadcast_block && (rx_data == 8'hff);
            end
            if (cnt_now == `MRF_LEN_HI_POS)
            begin
                s_d.len_field[15:8] = rx_data;
            end
            if (cnt_now == `MRF_LEN_LO_POS)
            begin
                s_d.len_field[7:0] = rx_data;
            end
            s_d.rx_out_valid = !drop_byte;
            s_d.rx_out_data = rx_data;
        end
        if (rx_eof)
        begin
            // host side throws away a frame ended without accept
            s_d.rx_out_end = 1'b1;
            s_d.rx_out_accept = accept_now;
            s_d.wake_event = s_q.wake_en && rx_wake_match;
        end

        // transmit retry control
        if (tx_frame_start)
        begin
            s_d.tx_attempts = 5'd0;
            s_d.tx_late = 1'b0;
        end
        else if (col_now)
        begin
            s_d.tx_attempts = att_next;
            s_d.tx_late = s_q.tx_late || tx_late_collision;
            s_d.tx_status = 32'h0000_0000;
            s_d.tx_status[`MRF_TXS_LATE] = s_q.tx_late || tx_late_collision;
            s_d.tx_status[`MRF_TXS_ATT_HI:`MRF_TXS_ATT_LO] = att_next;
            if (tx_late_collision && !late_retry)
            begin
                s_d.tx_abandon = 1'b1;
                s_d.tx_status_valid = 1'b1;
            end
            else if (single_tx || (att_next >= `MRF_MAX_ATTEMPTS))
            begin
                s_d.tx_abandon = 1'b1;
                s_d.tx_status_valid = 1'b1;
                s_d.tx_status[`MRF_TXS_RETRY_ERR] = 1'b1;
            end
            else
            begin
                s_d.tx_retry = 1'b1;
            end
        end
        else if (tx_done)
        begin
            s_d.tx_status_valid = 1'b1;
            s_d.tx_status = 32'h0000_0000;
            s_d.tx_status[`MRF_TXS_LATE] = s_q.tx_late;
            s_d.tx_status[`MRF_TXS_ATT_HI:`MRF_TXS_ATT_LO] = att_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            s_q <= '0;
            s_q.mac_control <= `MRF_RST_MAC_CONTROL;
            s_q.addr_high <= `MRF_RST_ADDR_HIGH;
            s_q.addr_low <= `MRF_RST_ADDR_LOW;
            s_q.hash_high <= `MRF_RST_HASH;
            s_q.hash_low <= `MRF_RST_HASH;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign rx_out_valid = s_q.rx_out_valid;
    assign rx_out_data = s_q.rx_out_data;
    assign rx_out_end = s_q.rx_out_end;
    assign rx_out_accept = s_q.rx_out_accept;
    assign wake_event = s_q.wake_event;
    assign tx_retry = s_q.tx_retry;
    assign tx_abandon = s_q.tx_abandon;
    assign tx_status_valid = s_q.tx_status_valid;
    assign tx_status = s_q.tx_status;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n_q);

    exact_filter_a: assert property (rx_eof && !hash_sel && !broadcast_block_now
        |=> rx_out_accept == $past(match_now))
        else $error("exact filter decision wrong");
    hash_mcast_a: assert property (rx_eof && hash_sel && mcast_now && !broadcast_block_now
        |=> rx_out_accept == $past(hash_hit))
        else $error("multicast hash decision wrong");
    hash_unicast_a: assert property (rx_eof && hash_sel && !mcast_now && hash_only
        |=> rx_out_accept == $past(hash_hit))
        else $error("hash-only unicast decision wrong");
    late_abandon_a: assert property (tx_late_collision && !late_retry && !tx_frame_start
        |=> tx_abandon && !tx_retry && tx_status_valid)
        else $error("late collision not abandoned");
    late_flag_a: assert property (tx_late_collision && !tx_frame_start
        |=> tx_status[`MRF_TXS_LATE])
        else $error("late collision not flagged");
    broadcast_block_drop_a: assert property (rx_eof && broadcast_block_now && broadcast_block_block
        |=> rx_out_end && !rx_out_accept)
        else $error("blocked broadcast accepted");
    wake_fire_a: assert property (rx_eof && s_q.wake_en && rx_wake_match
        |=> wake_event)
        else $error("wake event missed");
    single_try_a: assert property (tx_collision && !tx_late_collision && single_tx
        && !tx_frame_start
        |=> tx_abandon && tx_status[`MRF_TXS_RETRY_ERR] && !tx_retry)
        else $error("single attempt not dropped");
    retry_limit_a: assert property (col_now && !tx_frame_start && !single_tx
        && !tx_late_collision && s_q.tx_attempts == `MRF_MAX_ATTEMPTS - 5'd1
        |=> tx_abandon && tx_status[`MRF_TXS_RETRY_ERR])
        else $error("sixteenth attempt not abandoned");
    pad_drop_a: assert property (rx_valid && drop_byte |=> !rx_out_valid)
        else $error("pad byte not stripped");
    no_strip_a: assert property (rx_valid && !pad_strip
        |=> rx_out_valid && rx_out_data == $past(rx_data))
        else $error("unstripped byte lost");
    attempt_clear_a: assert property (tx_frame_start |=> s_q.tx_attempts == 5'd0)
        else $error("attempt count not restarted");
    apb_wait_a: assert property (apb_access && !pready |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

endmodule

`default_nettype wire

// file: hdl/mrf_map.svh
`ifndef MRF_MAP_SVH
`define MRF_MAP_SVH

// register indices; byte address is four times the index
`define MRF_IDX_MAC_CONTROL 6'h01
`define MRF_IDX_ADDR_HIGH 6'h02
`define MRF_IDX_ADDR_LOW 6'h03
`define MRF_IDX_HASH_HIGH 6'h04
`define MRF_IDX_HASH_LOW 6'h05
`define MRF_IDX_WAKE_CTRL 6'h0c
`define MRF_IDX_TX_STATUS 6'h10

// reset values
`define MRF_RST_MAC_CONTROL 32'h0004_0000
`define MRF_RST_ADDR_HIGH 16'hffff
`define MRF_RST_ADDR_LOW 32'hffff_ffff
`define MRF_RST_HASH 32'h0000_0000

// mac_control field positions
`define MRF_BIT_HASH_ONLY 15
`define MRF_BIT_HASH_SEL 13
`define MRF_BIT_LATE_RETRY 12
`define MRF_BIT_BROADCAST_BLOCK_BLOCK 11
`define MRF_BIT_SINGLE_TX 10
`define MRF_BIT_PAD_STRIP 8

// wake control field
`define MRF_BIT_WAKE_EN 2

// transmit status word fields
`define MRF_TXS_LATE 0
`define MRF_TXS_RETRY_ERR 1
`define MRF_TXS_ATT_LO 4
`define MRF_TXS_ATT_HI 8

// frame layout and limits
`define MRF_DA_LAST 11'd5
`define MRF_LEN_HI_POS 11'd12
`define MRF_LEN_LO_POS 11'd13
`define MRF_HDR_BYTES 16'd14
`define MRF_MIN_PAYLOAD 16'd46
`define MRF_MAX_ATTEMPTS 5'd16
`define MRF_CNT_MAX 11'h7ff

`endif

// file: hdl/mrf_pkg.sv
package mrf_pkg;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [31:0] mac_control;
        logic [15:0] addr_high;
        logic [31:0] addr_low;
        logic [31:0] hash_high;
        logic [31:0] hash_low;
        logic wake_en;
        logic [10:0] rx_cnt;
        logic da_match;
        logic da_broadcast_block;
        logic da_mcast;
        logic [15:0] len_field;
        logic rx_out_valid;
        logic [7:0] rx_out_data;
        logic rx_out_end;
        logic rx_out_accept;
        logic wake_event;
        logic [4:0] tx_attempts;
        logic tx_late;
        logic tx_retry;
        logic tx_abandon;
        logic tx_status_valid;
        logic [31:0] tx_status;
    } mrf_state_t;

endpackage

// file: tb/mac_rx_filter_tx_retry_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "mrf_map.svh"
`default_nettype none

module mac_rx_filter_tx_retry_ctrl_tb_top;
    localparam logic [47:0] station = 48'h6655_4433_2210;
    localparam logic [47:0] other_da = 48'h6755_4433_2210;
    localparam logic [47:0] mcast_da = 48'h0000_0000_0001;
    localparam logic [47:0] broadcast_block_da = 48'hffff_ffff_ffff;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_sof;
    logic rx_eof;
    logic [5:0] rx_hash_idx;
    logic rx_wake_match;
    logic rx_out_valid;
    logic [7:0] rx_out_data;
    logic rx_out_end;
    logic rx_out_accept;
    logic wake_event;
    logic [3:0] tx_ev;
    logic tx_retry;
    logic tx_abandon;
    logic tx_status_valid;
    logic [31:0] tx_status;
    logic acc;
    logic [31:0] st;
    logic [47:0] cur_da = 48'h0;
    logic [15:0] cur_len = 16'h0;
    int mismatches = 0;
    int total_checks = 0;
    int out_cnt;
    int wakes;
    int retries;
    int aborts;
    int stats;

    always #20 sys_clk = ~sys_clk;

    mrf_ctrl mrf_ctrl_i (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rx_valid, .rx_data, .rx_sof, .rx_eof, .rx_hash_idx,
        .rx_wake_match, .rx_out_valid, .rx_out_data, .rx_out_end, .rx_out_accept,
        .wake_event, .tx_frame_start(tx_ev[0]), .tx_collision(tx_ev[1]),
        .tx_late_collision(tx_ev[2]), .tx_done(tx_ev[3]), .tx_retry, .tx_abandon,
        .tx_status_valid, .tx_status);

    mrf_phy_model mrf_phy_model_i (.sys_clk, .rx_valid, .rx_data, .rx_sof, .rx_eof,
        .rx_hash_idx, .rx_wake_match, .tx_ev);

    always @(posedge sys_clk)
    begin
        if (rx_out_valid === 1'b1)
        begin
            // only trailing bytes are ever dropped, so the count is the byte index
            check({24'h0, rx_out_data}, {24'h0, exp_byte(out_cnt)});
            out_cnt++;
        end
        if (rx_out_end === 1'b1)
            acc = rx_out_accept;
        if (wake_event === 1'b1)
            wakes++;
        if (tx_retry === 1'b1)
            retries++;
        if (tx_abandon === 1'b1)
            aborts++;
        if (tx_status_valid === 1'b1)
        begin
            stats++;
            st = tx_status;
        end
    end

    function automatic logic [7:0] exp_byte(input int i);
        logic [7:0] v;
        v = 8'(i);
        if (i < 6)
            v = cur_da[8*i +: 8];
        if (i == 12)
            v = cur_len[15:8];
        if (i == 13)
            v = cur_len[7:0];
        return v;
    endfunction

    task automatic complete_run;
        if (mismatches == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // entered just after an edge; ends one idle cycle after the answer
    task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        // one wait state: the answer is sampled at the second access edge
        check(n, 2);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
        check({31'h0, e}, 32'h0);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 32'h0, r, e);
        check(r, x);
        check({31'h0, e}, {31'h0, xe});
    endtask

    task automatic rx_case(input logic [31:0] c, input logic [47:0] da, input logic [5:0] h,
        input logic wk, input logic [15:0] len, input int tot, input logic a, input int w,
        input int n);
        wr(`MRF_IDX_MAC_CONTROL, c);
        cur_da = da;
        cur_len = len;
        out_cnt = 0;
        wakes = 0;
        acc = 1'bx;
        mrf_phy_model_i.send(da, len, tot, h, wk);
        repeat (2) @(posedge sys_clk);
        check({31'h0, acc}, {31'h0, a});
        check(wakes, w);
        check(out_cnt, n);
    endtask

    task automatic tx_run(input logic [31:0] c, input int n, input logic [3:0] k1,
        input logic [3:0] k2, input int rt, input int ab, input logic [31:0] s);
        wr(`MRF_IDX_MAC_CONTROL, c);
        retries = 0;
        aborts = 0;
        stats = 0;
        mrf_phy_model_i.tx_event(4'h1);
        repeat (n) mrf_phy_model_i.tx_event(4'h2);
        mrf_phy_model_i.tx_event(k1);
        if (k2 != 4'h0)
            mrf_phy_model_i.tx_event(k2);
        repeat (2) @(posedge sys_clk);
        check(retries, rt);
        check(aborts, ab);
        check(stats, 1);
        check(st, s);
        rd(`MRF_IDX_TX_STATUS, s, 1'b0);
    endtask

    task automatic s_regs;
        logic [31:0] r;
        logic e;
        rd(`MRF_IDX_MAC_CONTROL, 32'h0004_0000, 1'b0);
        rd(`MRF_IDX_ADDR_HIGH, 32'h0000_ffff, 1'b0);
        rd(`MRF_IDX_ADDR_LOW, 32'hffff_ffff, 1'b0);
        rd(`MRF_IDX_HASH_LOW, 32'h0, 1'b0);
        rd(`MRF_IDX_WAKE_CTRL, 32'h0, 1'b0);
        apb(1'b1, 6'h08, 32'hffff_ffff, r, e);
        check({31'h0, e}, 32'h1);
        rd(6'h08, 32'h0, 1'b1);
        wr(`MRF_IDX_MAC_CONTROL, 32'h0000_8000);
        rd(`MRF_IDX_MAC_CONTROL, 32'h0000_8000, 1'b0);
        wr(`MRF_IDX_ADDR_LOW, station[31:0]);
        wr(`MRF_IDX_ADDR_HIGH, {16'h0, station[47:32]});
        wr(`MRF_IDX_HASH_LOW, 32'h0000_0008);
    endtask

    task automatic s_filter;
        rx_case(32'h0, station, 6'd3, 1'b0, 16'h0800, 20, 1'b1, 0, 20);
        rx_case(32'h0, other_da, 6'd3, 1'b0, 16'h0800, 20, 1'b0, 0, 20);
        rx_case(32'h0, mcast_da, 6'd3, 1'b0, 16'h0800, 20, 1'b0, 0, 20);
        rx_case(32'h2000, mcast_da, 6'd3, 1'b0, 16'h0800, 20, 1'b1, 0, 20);
        rx_case(32'h2000, mcast_da, 6'd4, 1'b0, 16'h0800, 20, 1'b0, 0, 20);
        rx_case(32'h2000, other_da, 6'd3, 1'b0, 16'h0800, 20, 1'b0, 0, 20);
        rx_case(32'h2000, station, 6'd4, 1'b0, 16'h0800, 20, 1'b1, 0, 20);
        rx_case(32'ha000, other_da, 6'd3, 1'b0, 16'h0800, 20, 1'b1, 0, 20);
        rx_case(32'ha000, station, 6'd4, 1'b0, 16'h0800, 20, 1'b0, 0, 20);
        rx_case(32'h0, broadcast_block_da, 6'd4, 1'b1, 16'h0800, 20, 1'b1, 0, 20);
        rx_case(32'h0800, broadcast_block_da, 6'd3, 1'b0, 16'h0800, 20, 1'b0, 0, 20);
        wr(`MRF_IDX_WAKE_CTRL, 32'h0000_0004);
        rx_case(32'h0800, broadcast_block_da, 6'd3, 1'b1, 16'h0800, 20, 1'b0, 1, 20);
    endtask

    task automatic s_pad;
        rx_case(32'h0100, station, 6'd0, 1'b0, 16'd20, 64, 1'b1, 0, 34);
        rx_case(32'h0100, station, 6'd0, 1'b0, 16'd45, 64, 1'b1, 0, 59);
        rx_case(32'h0100, station, 6'd0, 1'b0, 16'd46, 64, 1'b1, 0, 64);
        rx_case(32'h0, station, 6'd0, 1'b0, 16'd20, 64, 1'b1, 0, 64);
    endtask

    task automatic s_tx;
        tx_run(32'h0, 15, 4'h8, 4'h0, 15, 0, 32'h100);
        tx_run(32'h0, 15, 4'h2, 4'h0, 15, 1, 32'h102);
        tx_run(32'h0, 1, 4'h8, 4'h0, 1, 0, 32'h020);
        tx_run(32'h0400, 0, 4'h2, 4'h0, 0, 1, 32'h012);
        tx_run(32'h0, 0, 4'h4, 4'h0, 0, 1, 32'h011);
        tx_run(32'h1000, 0, 4'h4, 4'h8, 1, 0, 32'h021);
    endtask

    initial
    begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        s_regs();
        s_filter();
        s_pad();
        s_tx();
        complete_run();
    end

    // the sequence needs under a thousand cycles
    initial
    begin
        repeat (30000) @(posedge sys_clk);
        mismatches++;
        complete_run();
    end
endmodule

`default_nettype wire

// file: tb/mrf_phy_model.sv
`timescale 1ns/1ps
`default_nettype none

module mrf_phy_model (
    input wire logic sys_clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_sof,
    output logic rx_eof,
    output logic [5:0] rx_hash_idx,
    output logic rx_wake_match,
    output logic [3:0] tx_ev
);
    initial
    begin
        {rx_valid, rx_sof, rx_eof, rx_wake_match} = 4'h0;
        rx_data = 8'h00;
        rx_hash_idx = 6'h00;
        tx_ev = 4'h0;
    end

    // destination byte i is da[8*i +: 8]; bytes 12 and 13 hold the length field
    task automatic send(input logic [47:0] da, input logic [15:0] len, input int tot,
        input logic [5:0] h, input logic wk);
        logic [7:0] b;
        for (int i = 0; i < tot; i++)
        begin
            @(posedge sys_clk);
            b = (i < 6) ? da[8*i +: 8] : (i == 12) ? len[15:8] : (i == 13) ? len[7:0] : 8'(i);
            rx_valid <= 1'b1;
            rx_data <= b;
            rx_sof <= (i == 0);
            rx_eof <= (i == tot - 1);
            rx_hash_idx <= h;
            rx_wake_match <= wk;
        end
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_sof <= 1'b0;
        rx_eof <= 1'b0;
        // released lines show garbage, never the last value
        rx_data <= ~b;
        rx_hash_idx <= ~h;
        rx_wake_match <= ~wk;
    endtask

    // k = {done, late, collision, start}, one-cycle pulse
    task automatic tx_event(input logic [3:0] k);
        @(posedge sys_clk);
        tx_ev <= k;
        @(posedge sys_clk);
        tx_ev <= 4'h0;
    endtask
endmodule

`default_nettype wire
